// file: logic/pcicap_pkg.sv
// Package for the capability header register bank.
// Assumes one clock domain and configuration access from the link core.
`default_nettype none
package pcicap_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] CAP_BASE_ADDR      = 12'h0c0;
  localparam int          CAP_SPAN_BYTES     = 20;
  localparam logic [11:0] CAP_HEADER_ADDR    = 12'h0c0;
  localparam logic [11:0] DEV_CAPS_ADDR      = 12'h0c4;
  // ------------------------------------------------------------
  // Field values
  // ------------------------------------------------------------
  localparam logic [7:0]  CAP_IDENTIFIER     = 8'h10;
  localparam logic [7:0]  NEXT_CAP_LINK      = 8'h00;
  localparam logic [3:0]  CAP_REVISION       = 4'h1;
  localparam logic [3:0]  PORT_KIND_BRIDGE   = 4'h7;
  localparam logic [1:0]  SCALE_RESET        = 2'h0;
  localparam logic [7:0]  VALUE_RESET        = 8'h00;
  localparam logic [31:0] CAP_HEADER_RESET   = 32'h0071_0010;
  localparam logic [31:0] DEV_CAPS_RESET     = 32'h0000_8000;
  localparam logic [31:0] UNMAPPED_DATA      = 32'h0000_0000;

  // Slot power limit as delivered by the message decoder
  typedef struct packed {
    logic       valid;
    logic [1:0] scale;
    logic [7:0] value;
  } pcicap_power_msg_type;

  // Configuration access request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } pcicap_cfg_req_type;

  // Device capabilities word layout
  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] slot_power_scale;
    logic [7:0] slot_power_value;
    logic [1:0] rsvd_mid;
    logic       role_based_error_flag;
    logic [2:0] rsvd_legacy;
    logic [2:0] l1_acceptable_latency;
    logic [2:0] l0s_acceptable_latency;
    logic       wide_transaction_label_support;
    logic [1:0] phantom_function_support;
    logic [2:0] payload_limit_supported;
  } pcicap_dev_caps_type;
endpackage
`default_nettype wire

// file: logic/pcicap_regs.sv
// Capability header and device capabilities register bank.
// Assumes requests and power messages are synchronous to i_sys_clk.
//
// What this block does
// RQ1: Structure sits at 0x0C0, 20 bytes.
// RQ2: Header low byte reads 0x10.
// RQ3: Next capability link reads 0x00.
// RQ4: Capability revision reads one.
// RQ5: Port kind reads 0111, bridge.
// RQ6: Slot flag, message number, reserved read zero.
// RQ7: Scale captured from message, resets 00.
// RQ8: Value captured from message, resets zero.
// RQ9: Role-based error flag reads one.
// RQ10: Bits 14:12 read zero, writes ignored.
// RQ11: L1 latency reads zero.
// RQ12: L0s latency reads zero.
// RQ13: Wide transaction labels not supported.
// RQ14: Phantom function support reads zero.
// RQ15: Payload supported reads 128 bytes.
// RQ16: Any programmed payload means 128 bytes.
// RQ17: Writes change nothing; only messages update.
`timescale 1ns/1ps
`default_nettype none
module pcicap_regs (
  // Clock and reset
  input  wire logic                          i_sys_clk,
  input  wire logic                          i_reset_n,
  // Configuration access
  input  wire pcicap_pkg::pcicap_cfg_req_type i_cfg_req,
  output logic                               o_cfg_ack,
  output logic [31:0]                        o_cfg_rdata,
  // Slot power message capture
  input  wire pcicap_pkg::pcicap_power_msg_type i_power_msg,
  // Captured limit, for the power logic
  output logic [1:0]                         o_slot_power_scale,
  output logic [7:0]                         o_slot_power_value
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [1:0]  scale_ff, nxt_scale;
  logic [7:0]  value_ff, nxt_value;
  logic        ack_ff,   nxt_ack;
  logic [31:0] rdata_ff, nxt_rdata;

  // RQ1: window decode
  function automatic logic in_cap(input logic [11:0] a);
    return (a >= pcicap_pkg::CAP_BASE_ADDR) &&
           (a < pcicap_pkg::CAP_BASE_ADDR + 12'(pcicap_pkg::CAP_SPAN_BYTES));
  endfunction

  function automatic logic [31:0] header_word();
    // RQ2: fixed identifier
    // RQ3: end of list
    // RQ4: revision one
    // RQ5: bridge port kind
    // RQ6: upper bits zero
    return {8'h00, pcicap_pkg::PORT_KIND_BRIDGE, pcicap_pkg::CAP_REVISION,
            pcicap_pkg::NEXT_CAP_LINK, pcicap_pkg::CAP_IDENTIFIER};
  endfunction

  function automatic logic [31:0] caps_word(input logic [1:0] s, input logic [7:0] v);
    pcicap_pkg::pcicap_dev_caps_type c;
    c = '0;
    // RQ7: captured scale
    c.slot_power_scale = s;
    // RQ8: captured value
    c.slot_power_value = v;
    // RQ9: role-based reporting
    c.role_based_error_flag = 1'b1;
    // RQ10: legacy bits zero
    // RQ11: L1 latency zero
    // RQ12: L0s latency zero
    // RQ13: 5-bit tags only
    // RQ14: no phantoms
    // RQ15: 128-byte payload, so RQ16 holds for any control setting
    return c;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_scale = scale_ff;
    nxt_value = value_ff;
    // RQ17: only message capture updates
    if (i_power_msg.valid) begin
      nxt_scale = i_power_msg.scale;
      nxt_value = i_power_msg.value;
    end
    // Writes are acked but discarded, so software sees a completion
    nxt_ack   = i_cfg_req.rd | i_cfg_req.wr;
    nxt_rdata = pcicap_pkg::UNMAPPED_DATA;
    // Read returns the limit held before any same-cycle message
    if (i_cfg_req.rd) begin
      case (i_cfg_req.addr)
        pcicap_pkg::CAP_HEADER_ADDR: nxt_rdata = header_word();
        pcicap_pkg::DEV_CAPS_ADDR:   nxt_rdata = caps_word(scale_ff, value_ff);
        default:                     nxt_rdata = pcicap_pkg::UNMAPPED_DATA;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      scale_ff <= pcicap_pkg::SCALE_RESET;
      value_ff <= pcicap_pkg::VALUE_RESET;
      ack_ff   <= 1'b0;
      rdata_ff <= pcicap_pkg::UNMAPPED_DATA;
    end else begin
      scale_ff <= nxt_scale;
      value_ff <= nxt_value;
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_cfg_ack          = ack_ff;
  assign o_cfg_rdata        = rdata_ff;
  assign o_slot_power_scale = scale_ff;
  assign o_slot_power_value = value_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic window_hit;
  assign window_hit = in_cap(i_cfg_req.addr);
  // Caps reads, seen through the word layout
  logic                            caps_rd;
  pcicap_pkg::pcicap_dev_caps_type rdata_view;
  assign caps_rd    = i_cfg_req.rd && i_cfg_req.addr == pcicap_pkg::DEV_CAPS_ADDR;
  assign rdata_view = o_cfg_rdata;

  property p_hdr_read;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd && i_cfg_req.addr == pcicap_pkg::CAP_HEADER_ADDR |=>
        o_cfg_ack && o_cfg_rdata == pcicap_pkg::CAP_HEADER_RESET;
  endproperty
  a_hdr_read: assert property (p_hdr_read) else $error("header word wrong"); // RQ2

  property p_caps_idle;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd && i_cfg_req.addr == pcicap_pkg::DEV_CAPS_ADDR &&
      scale_ff == pcicap_pkg::SCALE_RESET && value_ff == pcicap_pkg::VALUE_RESET |=>
        o_cfg_rdata == pcicap_pkg::DEV_CAPS_RESET;
  endproperty
  a_caps_idle: assert property (p_caps_idle) else $error("caps word wrong"); // RQ9

  property p_caps_fixed;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd && i_cfg_req.addr == pcicap_pkg::DEV_CAPS_ADDR |=>
        o_cfg_rdata[14:0] == 15'h0000 && o_cfg_rdata[15] && o_cfg_rdata[31:28] == 4'h0;
  endproperty
  a_caps_fixed: assert property (p_caps_fixed) else $error("fixed caps bits"); // RQ10

  property p_scale_cap;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_power_msg.valid |=> o_slot_power_scale == $past(i_power_msg.scale);
  endproperty
  a_scale_cap: assert property (p_scale_cap) else $error("scale not captured"); // RQ7

  property p_value_cap;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_power_msg.valid ##1 (i_cfg_req.rd && i_cfg_req.addr == pcicap_pkg::DEV_CAPS_ADDR
        && !i_power_msg.valid) |=> o_cfg_rdata[25:18] == $past(i_power_msg.value, 2);
  endproperty
  a_value_cap: assert property (p_value_cap) else $error("value not captured"); // RQ8

  property p_write_inert;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.wr && !i_power_msg.valid |=> $stable(o_slot_power_scale) &&
        $stable(o_slot_power_value);
  endproperty
  a_write_inert: assert property (p_write_inert) else $error("write changed field"); // RQ17

  property p_hold;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !i_power_msg.valid [*2] |=> $stable(o_slot_power_value);
  endproperty
  a_hold: assert property (p_hold) else $error("value drifted"); // RQ8

  property p_outside;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd && !window_hit |=> o_cfg_ack &&
        o_cfg_rdata == pcicap_pkg::UNMAPPED_DATA;
  endproperty
  a_outside: assert property (p_outside) else $error("outside read nonzero"); // RQ1

  property p_inside_unmapped;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd && window_hit &&
        i_cfg_req.addr != pcicap_pkg::CAP_HEADER_ADDR &&
        i_cfg_req.addr != pcicap_pkg::DEV_CAPS_ADDR |=>
        o_cfg_rdata == pcicap_pkg::UNMAPPED_DATA;
  endproperty
  a_inside_unmapped: assert property (p_inside_unmapped) else $error("unmapped nonzero"); // RQ1

  // ------------------------------------------------------------
  // Checks: fixed capability fields
  // ------------------------------------------------------------
  property p_caps_l1;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.l1_acceptable_latency == '0;
  endproperty
  a_caps_l1: assert property (p_caps_l1) else $error("L1 latency not zero"); // RQ11

  property p_caps_l0s;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.l0s_acceptable_latency == '0;
  endproperty
  a_caps_l0s: assert property (p_caps_l0s) else $error("L0s latency not zero"); // RQ12

  property p_caps_tag;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.wide_transaction_label_support == 1'b0;
  endproperty
  a_caps_tag: assert property (p_caps_tag) else $error("wide labels claimed"); // RQ13

  property p_caps_phantom;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.phantom_function_support == '0;
  endproperty
  a_caps_phantom: assert property (p_caps_phantom) else $error("phantoms set"); // RQ14

  property p_caps_payload;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.payload_limit_supported == '0;
  endproperty
  a_caps_payload: assert property (p_caps_payload) else $error("payload not 128"); // RQ15 RQ16

  // ------------------------------------------------------------
  // Checks: captured limit
  // ------------------------------------------------------------
  property p_caps_scale;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.slot_power_scale == $past(o_slot_power_scale);
  endproperty
  a_caps_scale: assert property (p_caps_scale) else $error("scale field wrong"); // RQ7

  property p_caps_value;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      caps_rd |=> rdata_view.slot_power_value == $past(o_slot_power_value);
  endproperty
  a_caps_value: assert property (p_caps_value) else $error("value field wrong"); // RQ8

  property p_scale_hold;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !i_power_msg.valid |=> $stable(o_slot_power_scale);
  endproperty
  a_scale_hold: assert property (p_scale_hold) else $error("scale drifted"); // RQ7

  property p_msg_write;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.wr && i_power_msg.valid |=>
        o_slot_power_value == $past(i_power_msg.value) &&
        o_slot_power_scale == $past(i_power_msg.scale);
  endproperty
  a_msg_write: assert property (p_msg_write) else $error("message lost to write"); // RQ17

  // Checked while reset is active, so no disable here
  property p_reset_scale;
    @(posedge i_sys_clk)
      !i_reset_n |=> o_slot_power_scale == pcicap_pkg::SCALE_RESET;
  endproperty
  a_reset_scale: assert property (p_reset_scale) else $error("scale not reset"); // RQ7

  property p_reset_value;
    @(posedge i_sys_clk)
      !i_reset_n |=> o_slot_power_value == pcicap_pkg::VALUE_RESET && !o_cfg_ack;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("value not reset"); // RQ8

  // ------------------------------------------------------------
  // Checks: completions
  // ------------------------------------------------------------
  property p_rd_ack;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.rd |=> o_cfg_ack;
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read not completed"); // RQ1

  property p_write_ack;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      i_cfg_req.wr && !i_cfg_req.rd |=> o_cfg_ack &&
        o_cfg_rdata == pcicap_pkg::UNMAPPED_DATA;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write completion wrong"); // RQ17

  property p_idle_quiet;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !i_cfg_req.rd && !i_cfg_req.wr |=> !o_cfg_ack &&
        o_cfg_rdata == pcicap_pkg::UNMAPPED_DATA;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("spurious completion"); // RQ17

  // ------------------------------------------------------------
  // Covers
  // ------------------------------------------------------------

  c_hdr:   cover property (@(posedge i_sys_clk) i_cfg_req.rd &&
                           i_cfg_req.addr == pcicap_pkg::CAP_HEADER_ADDR);
  c_msg:   cover property (@(posedge i_sys_clk) i_power_msg.valid ##1 i_cfg_req.rd);
  c_write: cover property (@(posedge i_sys_clk) i_cfg_req.wr);
  c_unmapped:  cover property (@(posedge i_sys_clk) i_cfg_req.rd && !window_hit);
  c_msg_write: cover property (@(posedge i_sys_clk) i_cfg_req.wr && i_power_msg.valid);

endmodule
`default_nettype wire

// file: verification/pcicap_upstream_model.sv
// Upstream port model: configuration accesses and slot power messages.
// Assumes the bench calls step at a falling edge of the clock.
`timescale 1ns/1ps
`default_nettype none
module pcicap_upstream_model (
  // Clock
  input  wire logic                              i_sys_clk,
  // Traffic towards the bank
  output var pcicap_pkg::pcicap_cfg_req_type     o_cfg_req,
  output var pcicap_pkg::pcicap_power_msg_type   o_power_msg
);
  initial begin
    o_cfg_req   = '0;
    o_power_msg = '0;
  end
  // One cycle of traffic, held until the next falling edge
  task automatic step(input logic rd, input logic wr, input logic [11:0] a,
                      input logic pv, input logic [1:0] s, input logic [7:0] v);
    o_cfg_req   = {rd, wr, a, 32'($urandom)};
    o_power_msg = {pv, s, v};
    @(negedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// file: verification/tb.sv
// Bench for the capability register bank.
// Assumes the upstream model drives all requests at falling edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                              i_sys_clk = 1'b0;
  logic                              i_reset_n = 1'b0;
  pcicap_pkg::pcicap_cfg_req_type    i_cfg_req;
  pcicap_pkg::pcicap_power_msg_type  i_power_msg;
  logic                              o_cfg_ack;
  logic [31:0]                       o_cfg_rdata;
  logic [1:0]                        o_slot_power_scale;
  logic [7:0]                        o_slot_power_value;
  int                                failures = 0;
  int                                comparisons = 0;
  int                                cycles = 0;
  logic [11:0]                       holes [3] = '{12'h0bc, 12'h0c8, 12'h0d0};

  initial forever #2 i_sys_clk = ~i_sys_clk;

  pcicap_regs dut (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_cfg_req(i_cfg_req),
    .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata), .i_power_msg(i_power_msg),
    .o_slot_power_scale(o_slot_power_scale), .o_slot_power_value(o_slot_power_value));
  pcicap_upstream_model u_up (.i_sys_clk(i_sys_clk), .o_cfg_req(i_cfg_req),
    .o_power_msg(i_power_msg));

  function automatic logic [31:0] exp_caps(input logic [1:0] s, input logic [7:0] v);
    return {4'h0, s, v, 2'h0, 1'h1, 15'h0};
  endfunction

  // Read data for one request, given the limit held before that cycle
  function automatic logic [31:0] exp_read(input logic rd, input logic [11:0] a,
                                           input logic [1:0] s, input logic [7:0] v);
    if (!rd)
      return 32'h0;
    if (a == 12'h0c0)
      return 32'h0071_0010;
    if (a == 12'h0c4)
      return exp_caps(s, v);
    return 32'h0;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One cycle of traffic, answer checked a cycle later
  task automatic xfer(input logic rd, input logic wr, input logic [11:0] a,
                      input logic pv, input logic [9:0] sv, input logic [31:0] exp);
    u_up.step(rd, wr, a, pv, sv[9:8], sv[7:0]);
    chk("ack", {31'h0, o_cfg_ack}, {31'h0, rd | wr});
    chk("rdata", o_cfg_rdata, exp);
  endtask

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles used
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      conclude();
    end
  end

  initial begin
    logic [7:0]  v;
    logic        rd;
    logic        wr;
    logic        pv;
    logic [11:0] a;
    logic [9:0]  sv;
    logic [1:0]  es;
    logic [7:0]  ev;
    void'($urandom(70803));
    repeat (4) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    xfer(0, 0, 12'h000, 0, 10'h000, 32'h0);
    chk("power", {22'h0, o_slot_power_scale, o_slot_power_value}, 32'h0);
    xfer(1, 0, 12'h0c0, 0, 10'h000, 32'h0071_0010);
    xfer(1, 0, 12'h0c4, 0, 10'h000, exp_caps(2'h0, 8'h00));
    foreach (holes[i]) xfer(1, 0, holes[i], 0, 10'h000, 32'h0);
    for (int s = 0; s < 4; s++) begin
      v = 8'($urandom);
      xfer(0, 0, 12'h000, 1, {2'(s), v}, 32'h0);
      chk("power", {22'h0, o_slot_power_scale, o_slot_power_value}, {22'h0, 2'(s), v});
      xfer(1, 0, 12'h0c4, 0, 10'h000, exp_caps(2'(s), v));
    end
    xfer(0, 1, 12'h0c4, 0, 10'h000, 32'h0);
    xfer(0, 1, 12'h0c0, 0, 10'h000, 32'h0);
    xfer(1, 0, 12'h0c4, 0, 10'h000, exp_caps(2'h3, v));
    xfer(0, 1, 12'h0c4, 1, 10'h2a5, 32'h0);
    xfer(1, 0, 12'h0c0, 0, 10'h000, 32'h0071_0010);
    xfer(1, 0, 12'h0c4, 0, 10'h000, exp_caps(2'h2, 8'ha5));
    i_reset_n = 1'b0;
    xfer(0, 0, 12'h000, 0, 10'h000, 32'h0);
    i_reset_n = 1'b1;
    xfer(0, 0, 12'h000, 0, 10'h000, 32'h0);
    chk("power", {22'h0, o_slot_power_scale, o_slot_power_value}, 32'h0);
    xfer(1, 0, 12'h0c4, 0, 10'h000, exp_caps(2'h0, 8'h00));
    // Random back-to-back traffic; a read sees the limit held before its cycle
    es = 2'h0;
    ev = 8'h00;
    for (int n = 0; n < 300; n++) begin
      rd = 1'($urandom);
      wr = 1'($urandom);
      a  = 12'h0b0 + 12'(4 * $urandom_range(11));
      pv = 1'($urandom);
      sv = 10'($urandom);
      xfer(rd, wr, a, pv, sv, exp_read(rd, a, es, ev));
      if (pv) begin
        es = sv[9:8];
        ev = sv[7:0];
      end
      chk("power", {22'h0, o_slot_power_scale, o_slot_power_value}, {22'h0, es, ev});
    end
    xfer(0, 0, 12'h000, 0, 10'h000, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
